// >>> rtl/shevr_pkg.sv
// constants and types of the scsi host event reporter
`default_nettype none
package shevr_pkg;
    localparam logic [31:0] CODE_NONE   = 32'h0000_0000;
    localparam logic [31:0] CODE_RESET  = 32'h0000_0001;
    localparam logic [31:0] CODE_ASYNC  = 32'h0000_0002;
    localparam logic [31:0] CODE_PARAM  = 32'h0000_0003;
    localparam logic [31:0] LOST_FLAG   = 32'h8000_0000;
    localparam int          LOST_BIT    = 31;
    localparam logic [4:0]  MMC_TYPE    = 5'h05;
    localparam int FB_HOTPLUG = 1;
    localparam int FB_DRAIN   = 24;
    localparam int FB_LAYOUT  = 27;
    localparam int FB_INDIR   = 28;
    localparam int FB_EVIDX   = 29;
    localparam int FB_VER1    = 32;
    localparam logic [3:0] SK_ILLEGAL = 4'h5;
    localparam logic [3:0] SK_ATTN    = 4'h6;
    localparam logic [7:0] ASC_GONE   = 8'h25;
    localparam logic [7:0] ASCQ_GONE  = 8'h00;
    localparam logic [7:0] ASC_HARD   = 8'h29;
    localparam logic [7:0] ASCQ_HARD  = 8'h00;
    localparam logic [7:0] ASC_NEW    = 8'h3f;
    localparam logic [7:0] ASCQ_NEW   = 8'h0e;
    localparam logic [7:0] REC_BYTES  = 8'h10;
    localparam logic [7:0] CODE_BYTES = 8'h04;
    localparam logic [7:0] A_OFF_LO   = 8'h00;
    localparam logic [7:0] A_OFF_HI   = 8'h04;
    localparam logic [7:0] A_ACC_LO   = 8'h08;
    localparam logic [7:0] A_ACC_HI   = 8'h0c;
    localparam logic [7:0] A_EVSIZE   = 8'h10;
    localparam logic [7:0] A_SUBMASK  = 8'h14;
    localparam logic [7:0] A_CTRL     = 8'h18;
    localparam logic [7:0] A_STATUS   = 8'h1c;
    localparam logic [31:0] EVSIZE_RST = 32'h0000_0010;
    localparam int CTL_BE  = 0;
    localparam int CTL_FOK = 1;
    typedef enum logic [1:0] {K_RESET = 2'b00, K_ASYNC = 2'b01,
                              K_PARAM = 2'b10, K_NONE = 2'b11} shevr_kind_e;
    typedef enum logic [1:0] {R_HARD = 2'b00, R_RESCAN = 2'b01,
                              R_REMOVED = 2'b10} shevr_rsn_e;
    typedef enum logic [1:0] {S_IDLE = 2'b00, S_CHECK = 2'b01,
                              S_WRITE = 2'b10, S_DONE = 2'b11} shevr_state_e;
    typedef struct packed {
        shevr_kind_e kind;
        shevr_rsn_e  rsn;
        logic [63:0] lun;
        logic [31:0] info;
        logic [4:0]  ptype;
    } shevr_req_s;
    typedef struct packed {
        logic        valid;
        logic [1:0]  idx;
        logic [31:0] data;
    } shevr_wr_s;
    typedef struct packed {
        logic        valid;
        logic [3:0]  key;
        logic [7:0]  asc;
        logic [7:0]  ascq;
        logic [63:0] lun;
    } shevr_sense_s;
endpackage
`default_nettype wire

// >>> rtl/shevr_top.sv
// event record framer for the scsi host event queue
`default_nettype none
module shevr_top
    import shevr_pkg::*;
#(
    parameter bit TRANSITIONAL = 1'b1
)(
    input  wire logic         CLK_SYS,
    input  wire logic         RSTN,
    input  wire logic [7:0]   REG_ADDR,
    input  wire logic [31:0]  REG_WDATA,
    input  wire logic         REG_WR,
    input  wire logic         REG_RD,
    output var  logic [31:0]  REG_RDATA,
    input  wire logic         EV_VALID,
    input  wire shevr_req_s   EV_REQ,
    output var  logic         EV_READY,
    input  wire logic         BUF_AVAIL,
    input  wire logic [15:0]  BUF_LEN,
    output var  logic         BUF_TAKE,
    output var  shevr_wr_s    WR,
    output var  logic         DONE,
    output var  logic [7:0]   DONE_LEN,
    input  wire logic         SUPPRESS_IRQ,
    output var  logic         IRQ,
    output var  shevr_sense_s SENSE
);
    ////////////////////////////////////////////////////////////////////
    // offered features; bit 30 is never offered
    localparam logic [63:0] OFFER = (64'h1 << FB_VER1)
        | (64'h1 << FB_INDIR) | (64'h1 << FB_EVIDX)
        | (64'h1 << FB_HOTPLUG)
        | (TRANSITIONAL ? ((64'h1 << FB_LAYOUT)
                         | (64'h1 << FB_DRAIN)) : 64'h0);

    typedef struct packed {
        shevr_state_e st;
        shevr_req_s   req;
        logic         lost;
        logic         shrt;
        logic [1:0]   idx;
        logic [7:0]   drops;
        logic [31:0]  acc_lo;
        logic [31:0]  acc_hi;
        logic [31:0]  evsz;
        logic [31:0]  submask;
        logic [1:0]   ctl;
        logic         ev_rdy;
        logic         take;
        shevr_wr_s    wr;
        logic         done;
        logic [7:0]   dlen;
        shevr_sense_s sns;
        logic         irq;
        logic [31:0]  rdata;
    } shevr_regs_s;

    shevr_regs_s q;
    shevr_regs_s d;
    logic [63:0] neg;
    logic        hotplug;
    logic        halted;
    logic        swap;
    logic        keep;

    ////////////////////////////////////////////////////////////////////
    // whether a latched request may be posted at all
    function automatic logic keep_of(shevr_req_s r, logic hp,
                                     logic [31:0] sub);
        logic k;
        k = 1'b1;
        case (r.kind)
            K_RESET: k = (r.rsn == R_HARD) | hp;
            K_ASYNC: k = |(r.info & sub);
            K_PARAM: k = (r.ptype != MMC_TYPE);
            default: k = 1'b1;
        endcase
        return k;
    endfunction

    // event code per kind
    function automatic logic [31:0] code_of(shevr_kind_e k);
        logic [31:0] c;
        c = CODE_NONE;
        case (k)
            K_RESET: c = CODE_RESET;
            K_ASYNC: c = CODE_ASYNC;
            K_PARAM: c = CODE_PARAM;
            default: c = CODE_NONE;
        endcase
        return c;
    endfunction

    // guest byte order swap for legacy big-endian guests
    function automatic logic [31:0] bswap(logic [31:0] w);
        return {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction

    ////////////////////////////////////////////////////////////////////
    // negotiation state: accepted bits are masked by what was offered
    assign neg     = {q.acc_hi, q.acc_lo} & OFFER;
    assign hotplug = neg[FB_HOTPLUG];
    // refusing version compliance stops a non-transitional device
    assign halted  = q.ctl[CTL_FOK] & ~neg[FB_VER1] & ~TRANSITIONAL;
    assign swap    = ~neg[FB_VER1] & q.ctl[CTL_BE];
    assign keep    = keep_of(q.req, hotplug, q.submask);

    ////////////////////////////////////////////////////////////////////
    // next state of everything
    always_comb
    begin
        logic [31:0] w;
        logic        sh;
        w = 32'h0;
        sh = 1'b0;
        d = q;
        d.take = 1'b0;
        d.wr.valid = 1'b0;
        d.done = 1'b0;
        d.irq = 1'b0;
        d.sns.valid = 1'b0;
        d.rdata = 32'h0;
        // register writes
        if (REG_WR)
        begin
            case (REG_ADDR)
                A_ACC_LO:  d.acc_lo = REG_WDATA;
                A_ACC_HI:  d.acc_hi = REG_WDATA;
                A_EVSIZE:  d.evsz = REG_WDATA;
                A_SUBMASK: d.submask = REG_WDATA;
                A_CTRL:    d.ctl = REG_WDATA[1:0];
                default:   d.ctl = q.ctl;
            endcase
        end
        // register reads, data valid in the following cycle only
        if (REG_RD)
        begin
            case (REG_ADDR)
                A_OFF_LO:  d.rdata = OFFER[31:0];
                A_OFF_HI:  d.rdata = OFFER[63:32];
                A_ACC_LO:  d.rdata = q.acc_lo;
                A_ACC_HI:  d.rdata = q.acc_hi;
                A_EVSIZE:  d.rdata = q.evsz;
                A_SUBMASK: d.rdata = q.submask;
                A_CTRL:    d.rdata = {30'h0, q.ctl};
                A_STATUS:  d.rdata = {16'h0, q.drops, 5'h0,
                                      q.st != S_IDLE, halted, q.lost};
                default:   d.rdata = 32'h0;
            endcase
        end
        case (q.st)
            S_IDLE:
            begin
                d.ev_rdy = 1'b1;
                if (EV_VALID && q.ev_rdy)
                begin
                    d.req = EV_REQ;
                    d.st = S_CHECK;
                    d.ev_rdy = 1'b0;
                end
                else if (q.lost && BUF_AVAIL && !halted)
                begin
                    // empty record just to carry the lost flag; no stale lun from the last event
                    d.req = '0;
                    d.req.kind = K_NONE;
                    d.st = S_CHECK;
                    d.ev_rdy = 1'b0;
                end
            end
            S_CHECK:
            begin
                d.st = S_IDLE;
                // sense is raised whether or not a buffer is there
                d.sns.lun = q.req.lun;
                d.sns.key = SK_ATTN;
                if (q.req.kind == K_RESET)
                begin
                    d.sns.valid = 1'b1;
                    case (q.req.rsn)
                        R_REMOVED:
                        begin
                            d.sns.key = SK_ILLEGAL;
                            d.sns.asc = ASC_GONE;
                            d.sns.ascq = ASCQ_GONE;
                        end
                        R_RESCAN:
                        begin
                            d.sns.asc = ASC_NEW;
                            d.sns.ascq = ASCQ_NEW;
                        end
                        default:
                        begin
                            d.sns.asc = ASC_HARD;
                            d.sns.ascq = ASCQ_HARD;
                        end
                    endcase
                end
                if (q.req.kind == K_PARAM && keep)
                begin
                    d.sns.valid = 1'b1;
                    d.sns.asc = q.req.info[7:0];
                    d.sns.ascq = q.req.info[15:8];
                end
                // only subscribed notice bits survive
                d.req.info = (q.req.kind == K_ASYNC) ? (q.req.info & q.submask)
                                                     : q.req.info;
                if (halted || !keep)
                begin
                    d.st = S_IDLE;
                end
                else if (!BUF_AVAIL)
                begin
                    // no holding queue: a missing buffer loses the event
                    d.lost = 1'b1;
                    d.drops = (q.drops == 8'hff) ? q.drops : q.drops + 8'h01;
                end
                else
                begin
                    sh = {16'h0, BUF_LEN} < q.evsz;
                    d.take = 1'b1;
                    d.shrt = sh;
                    d.idx = 2'b00;
                    d.st = S_WRITE;
                    // a real event swallowed by a short buffer counts as lost
                    if (sh && q.req.kind != K_NONE)
                    begin
                        d.lost = 1'b1;
                    end
                end
            end
            S_WRITE:
            begin
                // code, lun bytes, reason in that order
                case (q.idx)
                    2'd0: w = (q.shrt ? CODE_NONE : code_of(q.req.kind))
                              | (q.lost ? LOST_FLAG : 32'h0);
                    // lun is a byte array and never swapped; lun 0 kept as is
                    2'd1: w = q.req.lun[31:0];
                    2'd2: w = q.req.lun[63:32];
                    default:
                    begin
                        case (q.req.kind)
                            K_RESET: w = {30'h0, q.req.rsn};
                            K_PARAM: w = {16'h0, q.req.info[15:0]};
                            K_ASYNC: w = q.req.info;
                            default: w = 32'h0;
                        endcase
                    end
                endcase
                if (swap && (q.idx == 2'd0 || q.idx == 2'd3))
                begin
                    w = bswap(w);
                end
                d.wr.valid = 1'b1;
                d.wr.idx = q.idx;
                d.wr.data = w;
                if (q.idx == 2'd0)
                begin
                    d.lost = 1'b0;
                end
                if (q.shrt || q.idx == 2'd3)
                begin
                    d.st = S_DONE;
                end
                else
                begin
                    d.idx = q.idx + 2'd1;
                end
            end
            S_DONE:
            begin
                // buffer goes back only once every word is out
                d.done = 1'b1;
                d.dlen = q.shrt ? CODE_BYTES : REC_BYTES;
                d.irq = ~SUPPRESS_IRQ
                      | (neg[FB_DRAIN] & ~BUF_AVAIL);
                d.st = S_IDLE;
                d.ev_rdy = 1'b1;
            end
            default:
            begin
                d.st = S_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            q <= '0;
            q.evsz <= EVSIZE_RST;
        end
        else
        begin
            q <= d;
        end
    end

    // outputs straight from the state flops
    assign REG_RDATA = q.rdata;
    assign EV_READY  = q.ev_rdy;
    assign BUF_TAKE  = q.take;
    assign WR        = q.wr;
    assign DONE      = q.done;
    assign DONE_LEN  = q.dlen;
    assign IRQ       = q.irq;
    assign SENSE     = q.sns;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);

    sequence full_rec_s;
        WR.valid && WR.idx == 2'd1 ##1 WR.valid && WR.idx == 2'd2
        ##1 WR.valid && WR.idx == 2'd3 ##1 DONE && DONE_LEN == REC_BYTES;
    endsequence

    sequence lost_post_s;
        q.st == S_CHECK && q.req.kind == K_NONE ##1 BUF_TAKE;
    endsequence

    rec_order_a: assert property (
        WR.valid && WR.idx == 2'd0 && !q.shrt |=> full_rec_s)
        else $error("record words out of order");

    lost_flag_a: assert property (
        WR.valid && WR.idx == 2'd0 && $past(q.lost) && !swap
        |-> WR.data[LOST_BIT])
        else $error("lost flag missing");

    drop_idle_a: assert property (
        q.st == S_CHECK && keep && !halted && !BUF_AVAIL
        |=> q.st == S_IDLE && q.lost && !BUF_TAKE)
        else $error("dropped event not flagged");

    short_buf_a: assert property (
        WR.valid && q.shrt |-> swap || WR.data[30:0] == 31'h0 ##1
        DONE && DONE_LEN == CODE_BYTES)
        else $error("short buffer not closed");

    lost_post_a: assert property (
        q.st == S_IDLE && q.lost && BUF_AVAIL && !halted
        && !(EV_VALID && q.ev_rdy) |=> lost_post_s)
        else $error("lost record not posted");

    hotplug_gate_a: assert property (
        WR.valid && WR.idx == 2'd3 && q.req.kind == K_RESET && !hotplug
        |-> WR.data == 32'h0)
        else $error("hot plug reason without feature");

    sense_map_a: assert property (
        SENSE.valid && SENSE.key == SK_ILLEGAL
        |-> SENSE.asc == ASC_GONE && SENSE.ascq == ASCQ_GONE)
        else $error("removal sense wrong");

    async_sub_a: assert property (
        WR.valid && WR.idx == 2'd3 && q.req.kind == K_ASYNC && !swap
        |-> (WR.data & ~q.submask) == 32'h0)
        else $error("unsubscribed notice bits");

    mmc_block_a: assert property (
        q.st == S_CHECK && q.req.kind == K_PARAM && q.req.ptype == MMC_TYPE
        |=> !BUF_TAKE && !SENSE.valid ##1 !WR.valid)
        else $error("param change for optical unit");

    offer_ver_a: assert property (
        REG_RD && REG_ADDR == A_OFF_HI |=> REG_RDATA[0] && !REG_RDATA[FB_VER1 - 32 + 1])
        else $error("version bit not offered");

    drain_irq_a: assert property (
        q.st == S_DONE && neg[FB_DRAIN] && !BUF_AVAIL |=> IRQ && DONE)
        else $error("drained interrupt missing");

endmodule // shevr_top
`default_nettype wire

// >>> verification/shevr_guest_model.sv
// guest driver model that stocks the event queue with buffers
`default_nettype none
module shevr_guest_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        stock_load,
    input  wire logic [3:0]  stock_cnt,
    input  wire logic [15:0] stock_len,
    input  wire logic        take,
    output logic             avail,
    output logic [15:0]      len
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0]  cnt_q;
    logic [15:0] len_q;

    ////////////////////////////////////////////////////////////////////////////
    // buffer stock, one buffer consumed per take
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= 4'h0;
            len_q <= 16'h0010;
        end
        else if (stock_load)
        begin
            cnt_q <= stock_cnt;
            len_q <= stock_len;
        end
        else if (take && cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
    end

    // empty queue shows a flipped length so a stale one cannot pass for valid
    assign avail = (cnt_q != 4'h0);
    assign len   = avail ? len_q : ~len_q;
endmodule // shevr_guest_model
`default_nettype wire

// >>> verification/shevr_top_tb_top.sv
// self-checking bench for the scsi host event reporter
`default_nettype none
module shevr_top_tb_top
    import shevr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic         clk_sys, rstn, reg_wr, reg_rd, ev_valid, ev_ready, buf_avail, buf_take;
    logic         done, suppress_irq, irq, stock_load;
    logic [7:0]   reg_addr, done_len, dlen;
    logic [31:0]  reg_wdata, reg_rdata;
    logic [15:0]  buf_len, stock_len;
    logic [3:0]   stock_cnt;
    shevr_req_s   ev_req;
    shevr_wr_s    wr;
    shevr_sense_s sense, sense_q;
    logic [31:0]  words [4];
    int           mismatches, checks_done, done_cnt, take_cnt, sense_cnt, irq_cnt;

    ////////////////////////////////////////////////////////////////////////////
    shevr_top #(.TRANSITIONAL(1'b1)) u_shevr_top (
        .CLK_SYS(clk_sys), .RSTN(rstn), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .EV_VALID(ev_valid),
        .EV_REQ(ev_req), .EV_READY(ev_ready), .BUF_AVAIL(buf_avail), .BUF_LEN(buf_len),
        .BUF_TAKE(buf_take), .WR(wr), .DONE(done), .DONE_LEN(done_len),
        .SUPPRESS_IRQ(suppress_irq), .IRQ(irq), .SENSE(sense)
    );

    shevr_guest_model u_shevr_guest_model (
        .clk(clk_sys), .rst_n(rstn), .stock_load(stock_load), .stock_cnt(stock_cnt),
        .stock_len(stock_len), .take(buf_take), .avail(buf_avail), .len(buf_len)
    );

    // clock
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // monitor: collects words, completions, sense and interrupt pulses
    always @(posedge clk_sys)
    begin
        if (wr.valid === 1'b1) words[wr.idx] <= wr.data;
        if (buf_take === 1'b1) take_cnt <= take_cnt + 1;
        if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
        if (sense.valid === 1'b1)
        begin
            sense_cnt <= sense_cnt + 1;
            sense_q   <= sense;
        end
        if (done === 1'b1)
        begin
            done_cnt <= done_cnt + 1;
            dlen     <= done_len;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string w);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(w, reg_rdata & m, e);
    endtask

    task automatic stock(input logic [3:0] n, input logic [15:0] l);
        @(posedge clk_sys);
        stock_load <= 1'b1;
        stock_cnt  <= n;
        stock_len  <= l;
        @(posedge clk_sys);
        stock_load <= 1'b0;
    endtask

    // bounded wait for a completion after count d0
    task automatic wait_done(input int d0);
        for (int n = 0; n < 20 && done_cnt == d0; n++)
            @(posedge clk_sys);
        #1;
    endtask

    task automatic post(input shevr_kind_e k, input shevr_rsn_e r, input logic [63:0] l,
                        input logic [31:0] inf, input logic [4:0] pt, input logic e);
        int d0;
        int t0;
        for (int n = 0; n < 50 && ev_ready !== 1'b1; n++)
        begin
            @(posedge clk_sys);
            #1;
        end
        chk("ready", {31'h0, ev_ready}, 32'h1);
        d0 = done_cnt;
        t0 = take_cnt;
        @(posedge clk_sys);
        ev_valid <= 1'b1;
        ev_req   <= '{kind: k, rsn: r, lun: l, info: inf, ptype: pt};
        @(posedge clk_sys);
        ev_valid <= 1'b0;
        wait_done(d0);
        chk("records", 32'(done_cnt - d0), {31'h0, e});
        chk("takes", 32'(take_cnt - t0), {31'h0, e});
    endtask

    task automatic rec_chk(input logic [31:0] code, input logic [63:0] l, input logic [31:0] rsn);
        chk("word0", words[0], code);
        chk("word1", words[1], l[31:0]);
        chk("word2", words[2], l[63:32]);
        chk("word3", words[3], rsn);
        chk("length", {24'h0, dlen}, {24'h0, REC_BYTES});
    endtask

    function automatic logic [19:0] sense_of(input shevr_rsn_e r);
        case (r)
            R_HARD:   return {SK_ATTN, ASC_HARD, ASCQ_HARD};
            R_RESCAN: return {SK_ATTN, ASC_NEW, ASCQ_NEW};
            default:  return {SK_ILLEGAL, ASC_GONE, ASCQ_GONE};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // watchdog: the whole sequence needs a few hundred cycles
    initial
    begin
        #200000;
        mismatches++;
        print_verdict();
    end

    // main sequence
    initial
    begin
        shevr_rsn_e  r;
        int          s0;
        int          i0;
        logic [63:0] lun;
        {reg_wr, reg_rd, ev_valid, suppress_irq, stock_load} = '0;
        {reg_addr, reg_wdata, stock_cnt} = '0;
        stock_len = 16'h0010;
        ev_req    = '0;
        lun       = 64'h0807_0605_0403_0201;
        rstn      = 1'b0;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;

        rd_chk(A_OFF_LO, 32'hffff_ffff, 32'h3900_0002, "offered lo");
        rd_chk(A_OFF_HI, 32'hffff_ffff, 32'h0000_0001, "offered hi");
        rd_chk(A_EVSIZE, 32'hffff_ffff, EVSIZE_RST, "event size");
        rd_chk(8'h20, 32'hffff_ffff, 32'h0, "unmapped");
        reg_write(A_ACC_LO, 32'h0800_0002); // hot plug and layout
        reg_write(A_ACC_HI, 32'h0000_0001);
        $display("test features done");

        stock(4'h5, 16'h0010);
        for (int i = 0; i < 3; i++)
        begin
            r = shevr_rsn_e'(i);
            post(K_RESET, r, lun, 32'h0, 5'h00, 1'b1);
            rec_chk(CODE_RESET, lun, {30'h0, r});
            chk("sense", {12'h0, sense_q.key, sense_q.asc, sense_q.ascq}, {12'h0, sense_of(r)});
            chk("sense lun", sense_q.lun[31:0], lun[31:0]);
        end
        // a rescan on lun 0 is what makes the driver rescan the whole target
        post(K_RESET, R_RESCAN, 64'h0, 32'h0, 5'h00, 1'b1);
        rec_chk(CODE_RESET, 64'h0, 32'h1);
        $display("test reset reasons done");

        reg_write(A_SUBMASK, 32'h0000_0014);
        post(K_ASYNC, R_HARD, lun, 32'h0000_0016, 5'h00, 1'b1);
        rec_chk(CODE_ASYNC, lun, 32'h0000_0014);
        post(K_ASYNC, R_HARD, lun, 32'h0000_0002, 5'h00, 1'b0);
        stock(4'h2, 16'h0010);
        post(K_PARAM, R_HARD, lun, 32'h0000_092a, 5'h00, 1'b1);
        rec_chk(CODE_PARAM, lun, 32'h0000_092a);
        chk("param sense", {12'h0, sense_q.key, sense_q.asc, sense_q.ascq}, {12'h0, SK_ATTN, 16'h2a09});
        post(K_PARAM, R_HARD, lun, 32'h0000_092a, MMC_TYPE, 1'b0);
        $display("test notices done");

        reg_write(A_ACC_LO, 32'h0800_0000);
        for (int i = 1; i < 3; i++)
        begin
            r  = shevr_rsn_e'(i);
            s0 = sense_cnt;
            post(K_RESET, r, lun, 32'h0, 5'h00, 1'b0);
            chk("sense count", 32'(sense_cnt - s0), 32'h1);
        end
        post(K_RESET, R_HARD, 64'h0, 32'h0, 5'h00, 1'b1);
        rec_chk(CODE_RESET, 64'h0, 32'h0);
        $display("test hot plug done");

        // the swallowed event already rides on the short record's flag
        stock(4'h1, 16'h0008);
        post(K_RESET, R_HARD, lun, 32'h0, 5'h00, 1'b1);
        chk("short word0", words[0], CODE_NONE | LOST_FLAG);
        chk("short length", {24'h0, dlen}, {24'h0, CODE_BYTES});
        post(K_RESET, R_HARD, lun, 32'h0, 5'h00, 1'b0);
        rd_chk(A_STATUS, 32'h1, 32'h1, "lost pending");
        s0 = done_cnt;
        stock(4'h1, 16'h0010);
        wait_done(s0);
        chk("lost word0", words[0], CODE_NONE | LOST_FLAG);
        chk("lost word1", words[1], 32'h0);
        chk("lost length", {24'h0, dlen}, {24'h0, REC_BYTES});
        rd_chk(A_STATUS, 32'h1, 32'h0, "lost cleared");
        $display("test lost events done");

        @(posedge clk_sys);
        suppress_irq <= 1'b1;
        stock(4'h2, 16'h0010);
        i0 = irq_cnt;
        post(K_RESET, R_HARD, lun, 32'h0, 5'h00, 1'b1);
        chk("suppressed irq", 32'(irq_cnt - i0), 32'h0);
        reg_write(A_ACC_LO, 32'h0900_0002);
        i0 = irq_cnt;
        post(K_RESET, R_HARD, lun, 32'h0, 5'h00, 1'b1);
        chk("drained irq", 32'(irq_cnt - i0), 32'h1);
        @(posedge clk_sys);
        suppress_irq <= 1'b0;
        stock(4'h2, 16'h0010);
        i0 = irq_cnt;
        post(K_RESET, R_HARD, lun, 32'h0, 5'h00, 1'b1);
        chk("plain irq", 32'(irq_cnt - i0), 32'h1);
        $display("test interrupts done");

        reg_write(A_ACC_HI, 32'h0);
        reg_write(A_CTRL, 32'h0000_0001);
        post(K_RESET, R_REMOVED, lun, 32'h0, 5'h00, 1'b1);
        rec_chk(32'h0100_0000, lun, 32'h0200_0000);
        $display("test legacy order done");
        print_verdict();
    end
endmodule // shevr_top_tb_top
`default_nettype wire
